// ==== pkg/czd_pkg.sv ====
// Opcode, addressing and timing constants for the opcode decode subset
`default_nettype none
package czd_pkg;
    // Opcodes of the covered instructions
    localparam logic [7:0] OP_TEST_DIR  = 8'h3D;
    localparam logic [7:0] OP_TEST_ACC  = 8'h4D;
    localparam logic [7:0] OP_TEST_IDX  = 8'h5D;
    localparam logic [7:0] OP_TEST_IX1  = 8'h6D;
    localparam logic [7:0] OP_TEST_IX   = 8'h7D;
    localparam logic [7:0] OP_COPY_X2A  = 8'h9F;
    localparam logic [7:0] OP_WAIT      = 8'h8F;
    // High nibbles of the indexed memory columns
    localparam logic [3:0] COL_IX       = 4'hF;
    localparam logic [3:0] COL_IX1      = 4'hE;
    localparam logic [3:0] COL_IX2      = 4'hD;
    // Cycle counts
    localparam logic [3:0] CYC_TEST_DIR = 4'h4;
    localparam logic [3:0] CYC_TEST_ACC = 4'h3;
    localparam logic [3:0] CYC_TEST_IDX = 4'h3;
    localparam logic [3:0] CYC_TEST_IX1 = 4'h5;
    localparam logic [3:0] CYC_TEST_IX  = 4'h4;
    localparam logic [3:0] CYC_COPY_X2A = 4'h2;
    localparam logic [3:0] CYC_WAIT     = 4'h2;
    localparam logic [3:0] CYC_ONE      = 4'h1;
    // Condition code bit positions
    localparam int CC_C = 0;
    localparam int CC_Z = 1;
    localparam int CC_N = 2;
    localparam int CC_I = 3;
    localparam int CC_H = 4;
    localparam int SIGN_BIT = 7;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] CC_RESET  = 8'hE8;

    typedef enum logic [3:0] {
        CZD_SUB, CZD_CMP, CZD_SBC, CZD_CPX, CZD_AND, CZD_BIT, CZD_LDA, CZD_STA,
        CZD_EOR, CZD_ADC, CZD_ORA, CZD_ADD, CZD_JMP, CZD_JSR, CZD_LDX, CZD_STX
    } czd_alu_op_t;

    typedef enum logic [2:0] {
        CZD_AM_NONE, CZD_AM_DIR, CZD_AM_EXT, CZD_AM_IX, CZD_AM_IX1, CZD_AM_IX2
    } czd_amode_t;
endpackage : czd_pkg
`default_nettype wire

// ==== rtl/czd_addr_calc.sv ====
// Effective address former for direct, extended and indexed modes
`default_nettype none
module czd_addr_calc
    import czd_pkg::*;
(
    input  wire czd_amode_t  amode_i,   // Addressing mode
    input  wire logic [7:0]  byte_hi_i, // First operand byte
    input  wire logic [7:0]  byte_lo_i, // Second operand byte
    input  wire logic [7:0]  index_i,   // Index register
    output logic      [15:0] ea_o       // Effective address
);
    wire [15:0] ea_dir = {ZERO_BYTE, byte_hi_i};
    wire [15:0] ea_ext = {byte_hi_i, byte_lo_i};
    wire [15:0] ea_ix  = {ZERO_BYTE, index_i};
    wire [15:0] ea_ix1 = {ZERO_BYTE, byte_hi_i} + {ZERO_BYTE, index_i};
    wire [15:0] ea_ix2 = {byte_hi_i, byte_lo_i} + {ZERO_BYTE, index_i};

    always_comb begin
        unique case (amode_i)
            CZD_AM_DIR: ea_o = ea_dir;
            CZD_AM_EXT: ea_o = ea_ext;
            CZD_AM_IX:  ea_o = ea_ix;
            CZD_AM_IX1: ea_o = ea_ix1;
            CZD_AM_IX2: ea_o = ea_ix2;
            default:    ea_o = 16'h0000;
        endcase
    end
endmodule : czd_addr_calc
`default_nettype wire

// ==== rtl/czd_decode.sv ====
// Opcode decoder for the zero test, index copy, wait and indexed columns
// Notes on behaviour
// - Zero test opcodes 3D direct, 4D acc, 5D index, 6D byte offset, 7D indexed.
// - Zero test updates only N and Z; takes 4, 3, 3, 5, 4 cycles.
// - 9F copies index into accumulator in 2 cycles, flags untouched.
// - 8F clears I, halts CPU clock until interrupt, 2 cycles.
// - Byte offset mode fetches one offset byte and adds index.
// - Word offset mode fetches two offset bytes, high then low.
// - Extended mode takes address from two bytes, high then low; czd_addr_calc forms it, but no decoded opcode selects it.
// - Direct mode uses one byte as address in low page.
// - High nibble F/E/D picks column; low nibble picks one of sixteen operations.
`default_nettype none
module czd_decode
    import czd_pkg::*;
(
    input  wire logic        clk_i,        // 20 MHz CPU clock
    input  wire logic        reset_i,      // Synchronous reset, active high
    input  wire logic        op_valid_i,   // Opcode byte on op_byte_i is new
    input  wire logic [7:0]  op_byte_i,    // Opcode byte from program memory
    input  wire logic        opnd_valid_i, // Operand byte on opnd_byte_i
    input  wire logic [7:0]  opnd_byte_i,  // Operand byte, in fetch order
    input  wire logic [7:0]  acc_i,        // Accumulator value
    input  wire logic [7:0]  index_i,      // Index register value
    input  wire logic [7:0]  mem_data_i,   // Operand read from memory
    input  wire logic [7:0]  cc_i,         // Condition code register in
    input  wire logic        irq_i,        // Interrupt request, same clock
    output logic             done_o,       // Instruction decoded, pulse
    output logic [3:0]       cycles_o,     // Cycles charged
    output logic [7:0]       cc_o,         // Condition code register out
    output logic             cc_we_o,      // Write cc_o back, pulse
    output logic [7:0]       acc_o,        // New accumulator value
    output logic             acc_we_o,     // Write acc_o back, pulse
    output logic             clk_halt_o,   // CPU clock held off
    output logic [15:0]      ea_o,         // Effective address
    output logic             ea_valid_o,   // ea_o valid, pulse
    output logic [3:0]       alu_op_o,     // Column operation select
    output logic             alu_valid_o   // alu_op_o valid, pulse
);
    typedef enum logic [1:0] {CZD_IDLE, CZD_OPND1, CZD_OPND2} czd_state_t;

    czd_state_t  state_reg, state_next;
    logic [7:0]  op_reg;
    logic [7:0]  hi_reg;
    logic [7:0]  lo_byte;
    czd_amode_t  amode;
    logic [1:0]  need;
    logic [15:0] ea_w;

    // Decode of a held opcode
    wire [3:0] op_hi    = op_reg[7:4];
    wire [3:0] op_lo    = op_reg[3:0];
    wire is_t_dir = (op_reg == OP_TEST_DIR);
    wire is_t_acc = (op_reg == OP_TEST_ACC);
    wire is_t_idx = (op_reg == OP_TEST_IDX);
    wire is_t_ix1 = (op_reg == OP_TEST_IX1);
    wire is_t_ix  = (op_reg == OP_TEST_IX);
    wire is_test  = is_t_dir | is_t_acc | is_t_idx | is_t_ix1 | is_t_ix;
    wire is_copy  = (op_reg == OP_COPY_X2A);
    wire is_wait  = (op_reg == OP_WAIT);
    wire col_ix   = (op_hi == COL_IX);
    wire col_ix1  = (op_hi == COL_IX1);
    wire col_ix2  = (op_hi == COL_IX2);
    wire is_col   = col_ix | col_ix1 | col_ix2;

    always_comb begin
        if (is_t_dir) amode = CZD_AM_DIR;
        else if (is_t_ix1 || col_ix1) amode = CZD_AM_IX1;
        else if (is_t_ix || col_ix) amode = CZD_AM_IX;
        else if (col_ix2) amode = CZD_AM_IX2;
        else amode = CZD_AM_NONE;
    end

    // Operand bytes still to fetch after the opcode
    always_comb begin
        unique case (amode)
            CZD_AM_DIR, CZD_AM_IX1: need = 2'd1;
            CZD_AM_IX2, CZD_AM_EXT: need = 2'd2;
            default:                need = 2'd0;
        endcase
    end

    // Tested value per form
    wire [7:0] tval = is_t_acc ? acc_i : (is_t_idx ? index_i : mem_data_i);
    wire       t_neg  = tval[SIGN_BIT];
    wire       t_zero = (tval == ZERO_BYTE);

    logic [7:0] cc_test;
    logic [7:0] cc_wait;
    always_comb begin
        cc_test = cc_i;
        cc_test[CC_N] = t_neg;
        cc_test[CC_Z] = t_zero;
        cc_wait = cc_i;
        cc_wait[CC_I] = 1'b0;
    end

    logic [3:0] cyc;
    always_comb begin
        if (is_t_dir) cyc = CYC_TEST_DIR;
        else if (is_t_acc) cyc = CYC_TEST_ACC;
        else if (is_t_idx) cyc = CYC_TEST_IDX;
        else if (is_t_ix1) cyc = CYC_TEST_IX1;
        else if (is_t_ix) cyc = CYC_TEST_IX;
        else if (is_copy) cyc = CYC_COPY_X2A;
        else if (is_wait) cyc = CYC_WAIT;
        else cyc = CYC_ONE;
    end

    // Held opcode stage: byte arrives, decode runs on the registered copy
    logic pending_reg;
    wire  finish = pending_reg && (state_reg == CZD_IDLE) && (need == 2'd0);
    wire  got1   = (state_reg == CZD_OPND1) && opnd_valid_i;
    wire  got2   = (state_reg == CZD_OPND2) && opnd_valid_i;
    wire  last   = finish || (got1 && need == 2'd1) || got2;
    assign lo_byte = got2 ? opnd_byte_i : ZERO_BYTE;
    wire [7:0] first_byte = got1 ? opnd_byte_i : hi_reg;

    czd_addr_calc u_addr (
        .amode_i   (amode),
        .byte_hi_i (first_byte),
        .byte_lo_i (lo_byte),
        .index_i   (index_i),
        .ea_o      (ea_w)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CZD_IDLE:  if (pending_reg && need != 2'd0) state_next = CZD_OPND1;
            CZD_OPND1: if (got1) state_next = (need == 2'd2) ? CZD_OPND2 : CZD_IDLE;
            CZD_OPND2: if (got2) state_next = CZD_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg   <= CZD_IDLE;
            pending_reg <= 1'b0;
            op_reg      <= 8'h00;
            hi_reg      <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (got1) hi_reg <= opnd_byte_i;                        // high first
            if (op_valid_i && !pending_reg && !clk_halt_o) begin
                op_reg      <= op_byte_i;
                pending_reg <= 1'b1;
            end else if (last) begin
                pending_reg <= 1'b0;
            end
        end
    end

    // Results, all registered
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            done_o      <= 1'b0;
            cycles_o    <= 4'h0;
            cc_o        <= CC_RESET;
            cc_we_o     <= 1'b0;
            acc_o       <= 8'h00;
            acc_we_o    <= 1'b0;
            clk_halt_o  <= 1'b0;
            ea_o        <= 16'h0000;
            ea_valid_o  <= 1'b0;
            alu_op_o    <= 4'h0;
            alu_valid_o <= 1'b0;
        end else begin
            done_o      <= last;
            cycles_o    <= last ? cyc : cycles_o;
            cc_we_o     <= last && (is_test || is_wait);
            cc_o        <= !last ? cc_o : (is_wait ? cc_wait : cc_test);
            acc_we_o    <= last && is_copy;
            acc_o       <= (last && is_copy) ? index_i : acc_o;
            ea_valid_o  <= last && (amode != CZD_AM_NONE);
            ea_o        <= last ? ea_w : ea_o;
            alu_valid_o <= last && is_col;
            alu_op_o    <= (last && is_col) ? op_lo : alu_op_o;
            // Interrupt wins over a same-cycle wait so no wake is lost
            if (irq_i) clk_halt_o <= 1'b0;
            else if (last && is_wait) clk_halt_o <= 1'b1;
        end
    end
endmodule : czd_decode
`default_nettype wire

// ==== testbench/czd_decode_monitor.sv ====
// Port checker for the opcode decode subset
`default_nettype none
module czd_decode_monitor
    import czd_pkg::*;
(
    input wire logic       clk_i,      // Clock
    input wire logic       reset_i,    // Reset
    input wire logic       irq_i,      // Wake
    input wire logic [7:0] index_i,    // Index
    input wire logic [7:0] cc_i,       // Flags in
    input wire logic       done_o,     // Done
    input wire logic [3:0] cycles_o,   // Cycles
    input wire logic [7:0] cc_o,       // Flags out
    input wire logic       cc_we_o,    // Flag write
    input wire logic [7:0] acc_o,      // Acc out
    input wire logic       acc_we_o,   // Acc write
    input wire logic       clk_halt_o, // Halted
    input wire logic       ea_valid_o  // Address valid
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_cyc_legal: assert property (done_o |-> cycles_o inside {[1:5]})
        else $error("cycle count out of range");
    a_hc_kept: assert property (cc_we_o |-> cc_o[CC_H] == $past(cc_i[CC_H])
        && cc_o[CC_C] == $past(cc_i[CC_C])) else $error("H or C changed");
    a_i_kept: assert property (cc_we_o && cycles_o != CYC_WAIT
        |-> cc_o[CC_I] == $past(cc_i[CC_I])) else $error("mask changed by test");
    a_wait_clr: assert property (cc_we_o && cycles_o == CYC_WAIT |-> !cc_o[CC_I])
        else $error("wait left mask set");
    a_copy_value: assert property (acc_we_o |-> acc_o == $past(index_i)
        && !cc_we_o && cycles_o == CYC_COPY_X2A) else $error("bad index copy");
    a_ea_done: assert property (ea_valid_o |-> done_o)
        else $error("address without done");
    a_halt_hold: assert property (clk_halt_o && !irq_i |=> clk_halt_o)
        else $error("halt dropped without wake");
    a_halt_wake: assert property (clk_halt_o && irq_i |=> !clk_halt_o)
        else $error("halt kept after wake");
    c_copy: cover property (acc_we_o);
    c_byte_off: cover property (cc_we_o && cycles_o == CYC_TEST_IX1);
    c_wake: cover property ($fell(clk_halt_o));
endmodule : czd_decode_monitor
`default_nettype wire

// ==== testbench/czd_prog_mem.sv ====
// Program memory model feeding opcode then operand bytes
`default_nettype none
module czd_prog_mem
    import czd_pkg::*;
(
    input  wire logic       clk_i,        // Clock
    input  wire logic       go_i,         // Start one instruction
    input  wire logic [7:0] op_i,         // Opcode
    input  wire logic [1:0] nb_i,         // Operand count
    input  wire logic [7:0] b0_i,         // First operand
    input  wire logic [7:0] b1_i,         // Second operand
    input  wire logic [3:0] gap_i,        // Stall cycles
    output var  logic       op_valid_o,   // Opcode strobe
    output var  logic [7:0] op_byte_o,    // Opcode bus
    output var  logic       opnd_valid_o, // Operand strobe
    output var  logic [7:0] opnd_byte_o   // Operand bus
);
    initial begin
        op_valid_o = 1'b0;
        op_byte_o = 8'h00;
        opnd_valid_o = 1'b0;
        opnd_byte_o = 8'h00;
    end
    // Released bus shows inverted junk, never the last byte
    always @(posedge clk_i) begin
        if (go_i) begin
            op_valid_o <= 1'b1;
            op_byte_o <= op_i;
            @(posedge clk_i);
            op_valid_o <= 1'b0;
            op_byte_o <= ~op_i;
            @(posedge clk_i);
            for (int k = 0; k < 32'(nb_i); k++) begin
                opnd_valid_o <= 1'b1;
                opnd_byte_o <= (k == 0) ? b0_i : b1_i;
                @(posedge clk_i);
                // No stall after the last byte, so the next start strobe is never missed
                if (gap_i != 4'h0 || k == 32'(nb_i) - 1) begin
                    opnd_valid_o <= 1'b0;
                    opnd_byte_o <= ~opnd_byte_o;
                end
                if (k < 32'(nb_i) - 1) begin
                    repeat (gap_i) @(posedge clk_i);
                end
            end
        end
    end
endmodule : czd_prog_mem
`default_nettype wire

// ==== testbench/czd_decode_test.sv ====
// Self-checking bench for the opcode decode subset
`default_nettype none
module czd_decode_test
    import czd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, reset_i, go, irq_i, op_valid_i, opnd_valid_i, done_o, cc_we_o, acc_we_o;
    logic clk_halt_o, ea_valid_o, alu_valid_o;
    logic [7:0] op_byte_i, opnd_byte_i, acc_i, index_i, mem_data_i, cc_i, cc_o, acc_o, v;
    logic [7:0] p_op, p_b0, p_b1, exp_cc;
    logic [3:0] cycles_o, alu_op_o, p_gap;
    logic [1:0] p_nb;
    logic [15:0] ea_o, exp_ea;
    int miscompares, cmp_count, seed, k;
    logic [7:0] t_op[5] = '{OP_TEST_DIR, OP_TEST_ACC, OP_TEST_IDX, OP_TEST_IX1, OP_TEST_IX};
    logic [3:0] t_cyc[5] = '{CYC_TEST_DIR, CYC_TEST_ACC, CYC_TEST_IDX, CYC_TEST_IX1, CYC_TEST_IX};
    logic [1:0] t_nb[5] = '{2'd1, 2'd0, 2'd0, 2'd1, 2'd0};
    czd_decode u_dut (.clk_i(clk_i), .reset_i(reset_i), .op_valid_i(op_valid_i),
        .op_byte_i(op_byte_i), .opnd_valid_i(opnd_valid_i), .opnd_byte_i(opnd_byte_i),
        .acc_i(acc_i), .index_i(index_i), .mem_data_i(mem_data_i), .cc_i(cc_i),
        .irq_i(irq_i), .done_o(done_o), .cycles_o(cycles_o), .cc_o(cc_o), .cc_we_o(cc_we_o),
        .acc_o(acc_o), .acc_we_o(acc_we_o), .clk_halt_o(clk_halt_o), .ea_o(ea_o),
        .ea_valid_o(ea_valid_o), .alu_op_o(alu_op_o), .alu_valid_o(alu_valid_o));
    czd_prog_mem u_mem (.clk_i(clk_i), .go_i(go), .op_i(p_op), .nb_i(p_nb), .b0_i(p_b0),
        .b1_i(p_b1), .gap_i(p_gap), .op_valid_o(op_valid_i), .op_byte_o(op_byte_i),
        .opnd_valid_o(opnd_valid_i), .opnd_byte_o(opnd_byte_i));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    // Random operands each time; mask forces zero data for the Z boundary
    task automatic run(input logic [7:0] op, input logic [1:0] nb, input logic [3:0] gap,
                       input logic [7:0] m);
        int n;
        acc_i <= 8'($random(seed)) & m;
        index_i <= 8'($random(seed)) & m;
        mem_data_i <= 8'($random(seed)) & m;
        cc_i <= 8'($random(seed));
        p_b0 <= 8'($random(seed));
        p_b1 <= 8'($random(seed));
        p_op <= op;
        p_nb <= nb;
        p_gap <= gap;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (done_o !== 1'b1 && n < 40);
        chk("done", 16'h0001, 16'(done_o));
    endtask : run
    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        finish_test();
    end
    initial begin
        seed = 32'hCA23804F;
        {reset_i, go, irq_i, acc_i, index_i, mem_data_i, cc_i} = {3'b100, 32'h0000_0000};
        {p_op, p_b0, p_b1, p_gap, p_nb} = 30'h0000_0000;
        repeat (2) @(posedge clk_i);
        #1;
        chk("cc reset", 16'(CC_RESET), 16'(cc_o));
        @(posedge clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            k = i % 5;
            run(t_op[k], t_nb[k], 4'(i % 3), (i < 5) ? 8'hFF : 8'h00);
            v = (k == 1) ? acc_i : (k == 2) ? index_i : mem_data_i;
            exp_cc = cc_i;
            exp_cc[CC_N] = v[SIGN_BIT];
            exp_cc[CC_Z] = (v == ZERO_BYTE);
            exp_ea = (k == 0) ? {8'h00, p_b0} : (k == 3) ? 16'(p_b0) + 16'(index_i) : 16'(index_i);
            chk("test cc", {8'h01, exp_cc}, {7'h00, cc_we_o, cc_o});
            chk("test cycles", 16'(t_cyc[k]), 16'(cycles_o));
            if (k != 1 && k != 2) chk("test ea", exp_ea, ea_o);
            chk("test ea valid", 16'(k != 1 && k != 2), 16'(ea_valid_o));
        end
        $display("test zero_test_op done");
        for (int i = 0; i < 48; i++) begin
            k = i / 16;
            run({COL_IX - 4'(k), 4'(i)}, 2'(k), 4'(i % 2), 8'hFF);
            exp_ea = 16'(index_i) + ((k == 0) ? 16'h0000 : (k == 1) ? 16'(p_b0) : {p_b0, p_b1});
            chk("column op", {11'h000, 1'b1, 4'(i)}, {11'h000, alu_valid_o, alu_op_o});
            chk("column ea", exp_ea, ea_o);
        end
        $display("test indexed columns done");
        run(OP_COPY_X2A, 2'd0, 4'h0, 8'hFF);
        chk("copy acc", {7'h01, 1'b0, index_i}, {7'h00, acc_we_o, cc_we_o, acc_o});
        chk("copy cycles", 16'(CYC_COPY_X2A), 16'(cycles_o));
        $display("test copy_index_to_acc done");
        run(OP_WAIT, 2'd0, 4'h0, 8'hFF);
        exp_cc = cc_i & 8'hF7;
        chk("wait cc", 16'(exp_cc), 16'(cc_o));
        chk("wait cycles", 16'(CYC_WAIT), 16'(cycles_o));
        repeat (3) @(posedge clk_i);
        #1;
        chk("halted", 16'h0001, 16'(clk_halt_o));
        @(posedge clk_i);
        irq_i <= 1'b1;
        @(posedge clk_i);
        irq_i <= 1'b0;
        #1;
        chk("woken", 16'h0000, 16'(clk_halt_o));
        $display("test wait done");
        finish_test();
    end
endmodule : czd_decode_test
bind czd_decode czd_decode_monitor u_mon (.clk_i(clk_i), .reset_i(reset_i), .irq_i(irq_i),
    .index_i(index_i), .cc_i(cc_i), .done_o(done_o), .cycles_o(cycles_o), .cc_o(cc_o),
    .cc_we_o(cc_we_o), .acc_o(acc_o), .acc_we_o(acc_we_o), .clk_halt_o(clk_halt_o),
    .ea_valid_o(ea_valid_o));
`default_nettype wire
